/* File: hw/tmon_pkg.sv */
// Constants, register map and bus states of the temperature monitor serial port.
package tmon_pkg;

	// ----------------------------------------------------------------
	// Read addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] RD_LOCAL_TEMP      = 8'h00;
	localparam logic [7:0] RD_REMOTE_TEMP_MSB = 8'h01;
	localparam logic [7:0] RD_STATUS          = 8'h02;
	localparam logic [7:0] RD_CONFIG          = 8'h03;
	localparam logic [7:0] RD_RATE            = 8'h04;
	localparam logic [7:0] RD_LOCAL_HIGH      = 8'h05;
	localparam logic [7:0] RD_LOCAL_LOW       = 8'h06;
	localparam logic [7:0] RD_REMOTE_HIGH_MSB = 8'h07;
	localparam logic [7:0] RD_REMOTE_LOW_MSB  = 8'h08;
	localparam logic [7:0] RD_REMOTE_TEMP_LSB = 8'h10;
	localparam logic [7:0] RD_MAKER_ID        = 8'hFE;

	// ----------------------------------------------------------------
	// Write addresses (shared ones are read at the same address)
	// ----------------------------------------------------------------
	localparam logic [7:0] WR_CONFIG          = 8'h09;
	localparam logic [7:0] WR_RATE            = 8'h0A;
	localparam logic [7:0] WR_LOCAL_HIGH      = 8'h0B;
	localparam logic [7:0] WR_LOCAL_LOW       = 8'h0C;
	localparam logic [7:0] WR_REMOTE_HIGH_MSB = 8'h0D;
	localparam logic [7:0] WR_REMOTE_LOW_MSB  = 8'h0E;
	localparam logic [7:0] WR_ONE_SHOT        = 8'h0F;
	localparam logic [7:0] RW_OFFSET_MSB      = 8'h11;
	localparam logic [7:0] RW_OFFSET_LSB      = 8'h12;
	localparam logic [7:0] RW_REMOTE_HIGH_LSB = 8'h13;
	localparam logic [7:0] RW_REMOTE_LOW_LSB  = 8'h14;
	localparam logic [7:0] RW_REMOTE_OT_LIMIT = 8'h19;
	localparam logic [7:0] RW_LOCAL_OT_LIMIT  = 8'h20;
	localparam logic [7:0] RW_HYSTERESIS      = 8'h21;
	localparam logic [7:0] RW_VIOLATION_COUNT = 8'h22;

	// ----------------------------------------------------------------
	// Reset values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_RATE       = 8'h08;
	localparam logic [7:0] RST_HIGH_LIMIT = 8'h55;
	localparam logic [7:0] RST_REMOTE_OT  = 8'h6C;
	localparam logic [7:0] RST_LOCAL_OT   = 8'h55;
	localparam logic [7:0] RST_HYST       = 8'h0A;
	localparam logic [7:0] RST_VIOLATION  = 8'h01;
	localparam logic [7:0] RST_POINTER    = 8'h00;
	localparam int         TIMEOUT_BIT    = 7;
	localparam int         COUNT_LSB      = 1;
	localparam int         COUNT_MSB      = 3;
	localparam int         STATUS_BUSY    = 7;
	localparam int         STATUS_LSB     = 2;
	localparam int         STATUS_MSB     = 6;

	// ----------------------------------------------------------------
	// Bus addresses and timing
	// ----------------------------------------------------------------
	localparam logic [6:0] DEV_ADDR_BASE  = 7'h4C;
	localparam logic [6:0] DEV_ADDR_ALT   = 7'h4D;
	localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
	localparam int         CLOCK_HZ       = 25_000_000;
	localparam int         TIMEOUT_US     = 25_000;
	localparam int         TIMEOUT_CYCLES = TIMEOUT_US * (CLOCK_HZ / 1_000_000);

	typedef enum logic [6:0] {
		S_IDLE     = 7'b000_0001,
		S_ADDR     = 7'b000_0010,
		S_ADDR_ACK = 7'b000_0100,
		S_WR_BYTE  = 7'b000_1000,
		S_WR_ACK   = 7'b001_0000,
		S_RD_BYTE  = 7'b010_0000,
		S_RD_ACK   = 7'b100_0000
	} bus_state_e;

endpackage

/* File: hw/thermal_monitor_smbus_port.sv */
// Two-wire slave port, register file and limit alert logic of the temperature monitor.
//
// What this block does
// - Alert only after programmed consecutive violation count
// - Violation count register resets to 0x01
// - Bit 7 enables 25 ms bus timeout
// - Answer the fixed device address, and the alert response address while alert is set
// - Start, then address MSB first, then direction
// - Acknowledge matching address before ninth clock
// - Direction 0 writes, direction 1 reads
// - Nine clocks per byte; data changes clock-low, except the release after lost arbitration
// - Writes one or two bytes, reads one
// - First written byte is pointer, second data
// - Reads return register selected by pointer
// - Separate read and write addresses only for registers 03..08
// - Data write to 0F triggers one measurement
// - Overtemp, high limit, hysteresis reset defaults
// - Open-drain alert pulls low on violation/open
// - Alert response read returns own address plus one
// - Lowest address wins alert response arbitration
// - Alert releases after response if condition gone
// - Violation: above high, or at/below low
// - Status read clears only vanished flags 6..2
`timescale 1ns/100ps

module thermal_monitor_smbus_port
#(
	parameter bit         ALT_VARIANT    = 1'b0,
	parameter logic [7:0] MAKER_ID       = 8'h5A, // Arbitrary identification value.
	parameter int         TIMEOUT_CYCLES = tmon_pkg::TIMEOUT_CYCLES
)
(
	input  wire logic       CLOCK,
	input  wire logic       RESET_N,
	input  wire logic       SCL_IN,
	input  wire logic       SERIAL_DATA_LINE_IN,
	output logic            SERIAL_DATA_LINE_OUT,
	output logic            SERIAL_DATA_LINE_OE,
	output logic            LIMIT_ALERT_OUT_N,
	output logic            LIMIT_ALERT_OE,
	input  wire logic [7:0] LOCAL_TEMP,
	input  wire logic [7:0] REMOTE_TEMP_MSB,
	input  wire logic [7:0] REMOTE_TEMP_LSB,
	input  wire logic       REMOTE_OPEN,
	input  wire logic       MEAS_DONE,
	input  wire logic       ADC_BUSY,
	input  wire logic [1:0] OVERTEMP_FLAGS,
	output logic            MEASURE_TRIGGER,
	output logic [7:0]      DEVICE_CONFIG,
	output logic [7:0]      MEASURE_RATE,
	output logic [7:0]      REMOTE_OFFSET_MSB,
	output logic [7:0]      REMOTE_OFFSET_LSB,
	output logic [7:0]      REMOTE_OVERTEMP_LIMIT,
	output logic [7:0]      LOCAL_OVERTEMP_LIMIT,
	output logic [7:0]      OVERTEMP_HYSTERESIS
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tmon_pkg::bus_state_e state;
	logic        scl_meta, scl_q, scl_p;
	logic        sda_meta, sda_q, sda_p;
	logic        scl_rise, scl_fall, start_seen, stop_seen;
	logic [3:0]  bit_cnt;
	logic [1:0]  byte_cnt;
	logic [7:0]  shift_in;
	logic [7:0]  shift_out;
	logic [7:0]  pointer;
	logic [7:0]  read_byte;
	logic        is_read, is_ara, wr_acked;
	logic        wr_strobe, status_read, ara_done;
	logic [6:0]  dev_addr;
	logic [7:0]  local_high, local_low, remote_high_msb, remote_low_msb;
	logic [7:0]  remote_high_lsb, remote_low_lsb, violation_cfg;
	logic [4:0]  flags, cond_now, next_cond;
	logic [2:0]  run_cnt, next_run;
	logic        alert_latch;
	logic [19:0] idle_cnt;
	logic        timeout_hit;

	assign dev_addr = ALT_VARIANT ? tmon_pkg::DEV_ADDR_ALT : tmon_pkg::DEV_ADDR_BASE;

	// Addresses that accept a data byte; the rest are refused with no acknowledge.
	function automatic logic is_writable(input logic [7:0] ptr);
		unique case (ptr)
			tmon_pkg::WR_CONFIG, tmon_pkg::WR_RATE, tmon_pkg::WR_LOCAL_HIGH,
			tmon_pkg::WR_LOCAL_LOW, tmon_pkg::WR_REMOTE_HIGH_MSB,
			tmon_pkg::WR_REMOTE_LOW_MSB, tmon_pkg::WR_ONE_SHOT,
			tmon_pkg::RW_OFFSET_MSB, tmon_pkg::RW_OFFSET_LSB,
			tmon_pkg::RW_REMOTE_HIGH_LSB, tmon_pkg::RW_REMOTE_LOW_LSB,
			tmon_pkg::RW_REMOTE_OT_LIMIT, tmon_pkg::RW_LOCAL_OT_LIMIT,
			tmon_pkg::RW_HYSTERESIS, tmon_pkg::RW_VIOLATION_COUNT:
				is_writable = 1'b1;
			default:
				is_writable = 1'b0;
		endcase
	endfunction

	// Codes 000, 001, 011, 111 give one to four; the count of ones plus one.
	function automatic logic [2:0] needed_runs(input logic [2:0] code);
		needed_runs = 3'(code[0]) + 3'(code[1]) + 3'(code[2]) + 3'd1;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and bus conditions
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			scl_meta <= 1'b1;
			scl_q    <= 1'b1;
			scl_p    <= 1'b1;
			sda_meta <= 1'b1;
			sda_q    <= 1'b1;
			sda_p    <= 1'b1;
		end
		else
		begin
			scl_meta <= SCL_IN;
			scl_q    <= scl_meta;
			scl_p    <= scl_q;
			sda_meta <= SERIAL_DATA_LINE_IN;
			sda_q    <= sda_meta;
			sda_p    <= sda_q;
		end
	end

	assign scl_rise   = scl_q && !scl_p;
	assign scl_fall   = !scl_q && scl_p;
	assign start_seen = scl_q && scl_p && sda_p && !sda_q;
	assign stop_seen  = scl_q && scl_p && !sda_p && sda_q;

	// ----------------------------------------------------------------
	// Read multiplexer
	// ----------------------------------------------------------------
	always_comb
	begin
		read_byte = 8'h00;
		if (is_ara)
			read_byte = {dev_addr, 1'b1};
		else
			unique case (pointer)
				tmon_pkg::RD_LOCAL_TEMP:      read_byte = LOCAL_TEMP;
				tmon_pkg::RD_REMOTE_TEMP_MSB: read_byte = REMOTE_TEMP_MSB;
				tmon_pkg::RD_STATUS:          read_byte = {ADC_BUSY, flags, OVERTEMP_FLAGS};
				tmon_pkg::RD_CONFIG:          read_byte = DEVICE_CONFIG;
				tmon_pkg::RD_RATE:            read_byte = MEASURE_RATE;
				tmon_pkg::RD_LOCAL_HIGH:      read_byte = local_high;
				tmon_pkg::RD_LOCAL_LOW:       read_byte = local_low;
				tmon_pkg::RD_REMOTE_HIGH_MSB: read_byte = remote_high_msb;
				tmon_pkg::RD_REMOTE_LOW_MSB:  read_byte = remote_low_msb;
				tmon_pkg::RD_REMOTE_TEMP_LSB: read_byte = REMOTE_TEMP_LSB;
				tmon_pkg::RW_OFFSET_MSB:      read_byte = REMOTE_OFFSET_MSB;
				tmon_pkg::RW_OFFSET_LSB:      read_byte = REMOTE_OFFSET_LSB;
				tmon_pkg::RW_REMOTE_HIGH_LSB: read_byte = remote_high_lsb;
				tmon_pkg::RW_REMOTE_LOW_LSB:  read_byte = remote_low_lsb;
				tmon_pkg::RW_REMOTE_OT_LIMIT: read_byte = REMOTE_OVERTEMP_LIMIT;
				tmon_pkg::RW_LOCAL_OT_LIMIT:  read_byte = LOCAL_OVERTEMP_LIMIT;
				tmon_pkg::RW_HYSTERESIS:      read_byte = OVERTEMP_HYSTERESIS;
				tmon_pkg::RW_VIOLATION_COUNT: read_byte = violation_cfg;
				tmon_pkg::RD_MAKER_ID:        read_byte = MAKER_ID;
				default:                      read_byte = 8'h00;
			endcase
	end

	// ----------------------------------------------------------------
	// Serial protocol engine
	// ----------------------------------------------------------------
	// Line changes are made on the falling clock edge, so data does not move while the host
	// holds the clock high, except the release after lost arbitration, made on the rising edge.
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			state                <= tmon_pkg::S_IDLE;
			bit_cnt              <= 4'h0;
			byte_cnt             <= 2'h0;
			shift_in             <= 8'h00;
			shift_out            <= 8'h00;
			pointer              <= tmon_pkg::RST_POINTER;
			is_read              <= 1'b0;
			is_ara               <= 1'b0;
			wr_acked             <= 1'b0;
			wr_strobe            <= 1'b0;
			status_read          <= 1'b0;
			ara_done             <= 1'b0;
			SERIAL_DATA_LINE_OE  <= 1'b0;
			SERIAL_DATA_LINE_OUT <= 1'b0;
		end
		else
		begin
			wr_strobe   <= 1'b0;
			status_read <= 1'b0;
			ara_done    <= 1'b0;
			if (start_seen)
			begin
				state               <= tmon_pkg::S_ADDR;
				bit_cnt             <= 4'h0;
				is_ara              <= 1'b0;
				SERIAL_DATA_LINE_OE <= 1'b0;
			end
			else if (stop_seen || timeout_hit)
			begin
				state               <= tmon_pkg::S_IDLE;
				is_ara              <= 1'b0;
				SERIAL_DATA_LINE_OE <= 1'b0;
			end
			else
				unique case (state)
					tmon_pkg::S_IDLE:
						SERIAL_DATA_LINE_OE <= 1'b0;
					tmon_pkg::S_ADDR:
						if (scl_rise)
						begin
							shift_in <= {shift_in[6:0], sda_q};
							bit_cnt  <= bit_cnt + 4'h1;
						end
						else if (scl_fall && bit_cnt == 4'h8)
						begin
							if (shift_in[7:1] == dev_addr)
							begin
								SERIAL_DATA_LINE_OE <= 1'b1;
								is_read             <= shift_in[0];
								state               <= tmon_pkg::S_ADDR_ACK;
							end
							else if (shift_in[7:1] == tmon_pkg::ALERT_RESP_ADDR
								&& shift_in[0] && alert_latch)
							begin
								SERIAL_DATA_LINE_OE <= 1'b1;
								is_read             <= 1'b1;
								is_ara              <= 1'b1;
								state               <= tmon_pkg::S_ADDR_ACK;
							end
							else
								state <= tmon_pkg::S_IDLE;
						end
					tmon_pkg::S_ADDR_ACK:
						if (scl_fall)
						begin
							bit_cnt <= 4'h0;
							if (is_read)
							begin
								shift_out           <= read_byte;
								SERIAL_DATA_LINE_OE <= !read_byte[7];
								status_read         <= !is_ara && pointer == tmon_pkg::RD_STATUS;
								state               <= tmon_pkg::S_RD_BYTE;
							end
							else
							begin
								SERIAL_DATA_LINE_OE <= 1'b0;
								byte_cnt            <= 2'h0;
								state               <= tmon_pkg::S_WR_BYTE;
							end
						end
					tmon_pkg::S_WR_BYTE:
						if (scl_rise)
						begin
							shift_in <= {shift_in[6:0], sda_q};
							bit_cnt  <= bit_cnt + 4'h1;
						end
						else if (scl_fall && bit_cnt == 4'h8)
						begin
							state <= tmon_pkg::S_WR_ACK;
							if (byte_cnt == 2'h0)
							begin
								pointer             <= shift_in;
								SERIAL_DATA_LINE_OE <= 1'b1;
								wr_acked            <= 1'b1;
							end
							else if (byte_cnt == 2'h1 && is_writable(pointer))
							begin
								wr_strobe           <= 1'b1;
								SERIAL_DATA_LINE_OE <= 1'b1;
								wr_acked            <= 1'b1;
							end
							else
								wr_acked <= 1'b0;
						end
					tmon_pkg::S_WR_ACK:
						if (scl_fall)
						begin
							SERIAL_DATA_LINE_OE <= 1'b0;
							bit_cnt             <= 4'h0;
							byte_cnt            <= byte_cnt + 2'h1;
							state <= wr_acked ? tmon_pkg::S_WR_BYTE : tmon_pkg::S_IDLE;
						end
					tmon_pkg::S_RD_BYTE:
						if (scl_rise)
						begin
							bit_cnt <= bit_cnt + 4'h1;
							if (shift_out[7] && !sda_q)
							begin
								// Another device pulled a one low: it has the lower address.
								SERIAL_DATA_LINE_OE <= 1'b0;
								state               <= tmon_pkg::S_IDLE;
							end
						end
						else if (scl_fall)
						begin
							if (bit_cnt == 4'h8)
							begin
								SERIAL_DATA_LINE_OE <= 1'b0;
								state               <= tmon_pkg::S_RD_ACK;
							end
							else
							begin
								shift_out           <= {shift_out[6:0], 1'b0};
								SERIAL_DATA_LINE_OE <= !shift_out[6];
							end
						end
					tmon_pkg::S_RD_ACK:
						if (scl_rise)
						begin
							// Only one byte per read; the line stays released afterwards.
							ara_done <= is_ara;
							is_ara   <= 1'b0;
							state    <= tmon_pkg::S_IDLE;
						end
				endcase
		end
	end

	// ----------------------------------------------------------------
	// Bus timeout
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			idle_cnt    <= 20'h0_0000;
			timeout_hit <= 1'b0;
		end
		else if (state == tmon_pkg::S_IDLE || scl_rise || scl_fall || sda_q != sda_p
			|| !violation_cfg[tmon_pkg::TIMEOUT_BIT])
		begin
			idle_cnt    <= 20'h0_0000;
			timeout_hit <= 1'b0;
		end
		else
		begin
			idle_cnt    <= idle_cnt + 20'h0_0001;
			timeout_hit <= idle_cnt == 20'(TIMEOUT_CYCLES - 1);
		end
	end

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			DEVICE_CONFIG         <= tmon_pkg::RST_ZERO;
			MEASURE_RATE          <= tmon_pkg::RST_RATE;
			local_high            <= tmon_pkg::RST_HIGH_LIMIT;
			local_low             <= tmon_pkg::RST_ZERO;
			remote_high_msb       <= tmon_pkg::RST_HIGH_LIMIT;
			remote_low_msb        <= tmon_pkg::RST_ZERO;
			REMOTE_OFFSET_MSB     <= tmon_pkg::RST_ZERO;
			REMOTE_OFFSET_LSB     <= tmon_pkg::RST_ZERO;
			remote_high_lsb       <= tmon_pkg::RST_ZERO;
			remote_low_lsb        <= tmon_pkg::RST_ZERO;
			REMOTE_OVERTEMP_LIMIT <= tmon_pkg::RST_REMOTE_OT;
			LOCAL_OVERTEMP_LIMIT  <= tmon_pkg::RST_LOCAL_OT;
			OVERTEMP_HYSTERESIS   <= tmon_pkg::RST_HYST;
			violation_cfg         <= tmon_pkg::RST_VIOLATION;
			MEASURE_TRIGGER       <= 1'b0;
		end
		else
		begin
			MEASURE_TRIGGER <= 1'b0;
			if (wr_strobe)
				unique case (pointer)
					tmon_pkg::WR_CONFIG:          DEVICE_CONFIG <= shift_in;
					tmon_pkg::WR_RATE:            MEASURE_RATE <= shift_in;
					tmon_pkg::WR_LOCAL_HIGH:      local_high <= shift_in;
					tmon_pkg::WR_LOCAL_LOW:       local_low <= shift_in;
					tmon_pkg::WR_REMOTE_HIGH_MSB: remote_high_msb <= shift_in;
					tmon_pkg::WR_REMOTE_LOW_MSB:  remote_low_msb <= shift_in;
					tmon_pkg::WR_ONE_SHOT:        MEASURE_TRIGGER <= 1'b1;
					tmon_pkg::RW_OFFSET_MSB:      REMOTE_OFFSET_MSB <= shift_in;
					tmon_pkg::RW_OFFSET_LSB:      REMOTE_OFFSET_LSB <= shift_in;
					tmon_pkg::RW_REMOTE_HIGH_LSB: remote_high_lsb <= shift_in;
					tmon_pkg::RW_REMOTE_LOW_LSB:  remote_low_lsb <= shift_in;
					tmon_pkg::RW_REMOTE_OT_LIMIT: REMOTE_OVERTEMP_LIMIT <= shift_in;
					tmon_pkg::RW_LOCAL_OT_LIMIT:  LOCAL_OVERTEMP_LIMIT <= shift_in;
					tmon_pkg::RW_HYSTERESIS:      OVERTEMP_HYSTERESIS <= shift_in;
					tmon_pkg::RW_VIOLATION_COUNT: violation_cfg <= shift_in;
					default:                      MEASURE_TRIGGER <= 1'b0;
				endcase
		end
	end

	// ----------------------------------------------------------------
	// Limit comparison, status flags and alert latch
	// ----------------------------------------------------------------
	// Remote values compare on the ten valid bits, high byte first.
	always_comb
	begin
		next_cond[4] = LOCAL_TEMP > local_high;
		next_cond[3] = LOCAL_TEMP <= local_low;
		next_cond[2] = {REMOTE_TEMP_MSB, REMOTE_TEMP_LSB[7:6]}
			> {remote_high_msb, remote_high_lsb[7:6]};
		next_cond[1] = {REMOTE_TEMP_MSB, REMOTE_TEMP_LSB[7:6]}
			<= {remote_low_msb, remote_low_lsb[7:6]};
		next_cond[0] = REMOTE_OPEN;
		next_run     = (run_cnt == 3'd4) ? run_cnt : run_cnt + 3'd1;
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			cond_now <= 5'h00;
			flags    <= 5'h00;
			run_cnt  <= 3'd0;
		end
		else
		begin
			if (MEAS_DONE)
			begin
				cond_now <= next_cond;
				run_cnt  <= (next_cond != 5'h00) ? next_run : 3'd0;
			end
			// A new measurement's flags win over a clear in the same cycle.
			if (MEAS_DONE && status_read)
				flags <= (flags & cond_now) | next_cond;
			else if (MEAS_DONE)
				flags <= flags | next_cond;
			else if (status_read)
				flags <= flags & cond_now;
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			alert_latch <= 1'b0;
		else if (MEAS_DONE && next_cond != 5'h00
			&& next_run >= needed_runs(violation_cfg[tmon_pkg::COUNT_MSB:tmon_pkg::COUNT_LSB]))
			alert_latch <= 1'b1;
		else if (ara_done && cond_now == 5'h00)
			alert_latch <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Open-drain alert pin
	// ----------------------------------------------------------------
	assign LIMIT_ALERT_OE    = alert_latch;
	assign LIMIT_ALERT_OUT_N = SERIAL_DATA_LINE_OUT;

endmodule

/* File: verification/port_monitor.sv */
// Checker of the serial port pins, bound to the port's top module.
`timescale 1ns/100ps
module port_monitor
(
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic SCL_IN,
	input wire logic SERIAL_DATA_LINE_IN,
	input wire logic SERIAL_DATA_LINE_OUT,
	input wire logic SERIAL_DATA_LINE_OE,
	input wire logic LIMIT_ALERT_OE,
	input wire logic MEAS_DONE,
	input wire logic MEASURE_TRIGGER
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	AST_DATA_OPEN_DRAIN: assert property (SERIAL_DATA_LINE_OE |-> !SERIAL_DATA_LINE_OUT)
		else $error("data driven high");
	// The pin synchronisers lag two or three cycles, so the look-back depths leave that margin.
	AST_DATA_STEADY_HIGH: assert property (SCL_IN && $past(SCL_IN) && $past(SCL_IN, 2)
		&& $past(SCL_IN, 3) |-> $stable(SERIAL_DATA_LINE_OE)) else $error("data moved, clock high");
	AST_ACK_CLOCK_LOW: assert property ($rose(SERIAL_DATA_LINE_OE)
		|-> !$past(SCL_IN) && !$past(SCL_IN, 2)) else $error("data pulled, clock high");
	AST_STOP_RELEASE: assert property (SCL_IN && $rose(SERIAL_DATA_LINE_IN)
		|=> !SERIAL_DATA_LINE_OE [*4]) else $error("data pulled after stop");
	AST_TRIGGER_PULSE: assert property (MEASURE_TRIGGER |=> !MEASURE_TRIGGER)
		else $error("trigger too long");
	AST_TRIGGER_ACKED: assert property (MEASURE_TRIGGER |-> ##[0:3] SERIAL_DATA_LINE_OE)
		else $error("trigger without ack");
	AST_ALERT_SET: assert property ($rose(LIMIT_ALERT_OE) |-> $past(MEAS_DONE))
		else $error("alert without measurement");
	AST_ALERT_CLEAR: assert property ($fell(LIMIT_ALERT_OE) |-> $past(SCL_IN, 2))
		else $error("alert cleared off the clock");
endmodule

bind thermal_monitor_smbus_port port_monitor port_monitor_inst
(
	.CLOCK(CLOCK), .RESET_N(RESET_N), .SCL_IN(SCL_IN),
	.SERIAL_DATA_LINE_IN(SERIAL_DATA_LINE_IN), .SERIAL_DATA_LINE_OUT(SERIAL_DATA_LINE_OUT),
	.SERIAL_DATA_LINE_OE(SERIAL_DATA_LINE_OE), .LIMIT_ALERT_OE(LIMIT_ALERT_OE),
	.MEAS_DONE(MEAS_DONE), .MEASURE_TRIGGER(MEASURE_TRIGGER)
);

/* File: verification/host_model.sv */
// Bus host model: an open-drain master clocking the serial port at 320 ns.
`timescale 1ns/100ps
module host_model
(
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial scl = 1'b1;
	initial sda_low = 1'b0;
	task automatic q(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic start();
		q(2);
		sda_low <= 1'b1;
		q(2);
		scl <= 1'b0;
	endtask
	// Bit 0 is the ninth clock; the host leaves it released, so reads end unacknowledged.
	task automatic xfer9(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			sda_low <= !tx[i];
			q(2);
			scl <= 1'b1;
			q(2);
			rx[i] = sda;
			q(2);
			scl <= 1'b0;
			q(2);
		end
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		q(2);
		scl <= 1'b1;
		q(2);
		sda_low <= 1'b0;
		q(2);
	endtask
endmodule

/* File: verification/testbench.sv */
// Self-checking bench: host model, serial port and a measurement stub.
`timescale 1ns/100ps
module testbench;
	localparam int TO = 200;
	logic        clock = 1'b0, reset_n = 1'b0, done = 1'b0, busy = 1'b0;
	logic [1:0]  flags = 2'b00;
	logic [7:0]  ltemp = 8'h00;
	logic [16:0] lfsr  = 17'h1_3450;
	logic        scl, host_low, sda_oe, alert_oe, trig;
	logic [7:0]  cfg, v, rate, rot, hyst;
	logic [7:0]  rtemp = 8'h20, rtemp_lo = 8'h00;
	logic        ropen = 1'b0;
	logic [3:0]  ack;
	logic [8:0]  r;
	int          failures, samples_checked, trig_count, run;
	logic [7:0]  rst_addr [9] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h19, 8'h20, 8'h21, 8'h22, 8'hFE};
	logic [7:0]  rst_val  [9] = '{8'h00, 8'h08, 8'h55, 8'h55, 8'h6C, 8'h55, 8'h0A, 8'h01, 8'h3C};
	logic [7:0]  temps    [6] = '{8'h60, 8'h60, 8'h55, 8'h60, 8'h60, 8'h60};
	wire         sda = !(host_low || sda_oe);
	always #20 clock = !clock;
	always @(posedge clock) if (trig) trig_count++;
	host_model host_model_inst (.clk(clock), .sda(sda), .scl(scl), .sda_low(host_low));
	// MAKER_ID is arbitrary; the timeout is cut short so the run stays brief.
	thermal_monitor_smbus_port #(.MAKER_ID(8'h3C), .TIMEOUT_CYCLES(TO)) thermal_monitor_smbus_port_inst
	(
		.CLOCK(clock), .RESET_N(reset_n), .SCL_IN(scl), .SERIAL_DATA_LINE_IN(sda),
		.SERIAL_DATA_LINE_OUT(), .SERIAL_DATA_LINE_OE(sda_oe), .LIMIT_ALERT_OUT_N(),
		.LIMIT_ALERT_OE(alert_oe), .LOCAL_TEMP(ltemp), .REMOTE_TEMP_MSB(rtemp),
		.REMOTE_TEMP_LSB(rtemp_lo), .REMOTE_OPEN(ropen), .MEAS_DONE(done), .ADC_BUSY(busy),
		.OVERTEMP_FLAGS(flags), .MEASURE_TRIGGER(trig), .DEVICE_CONFIG(cfg),
		.MEASURE_RATE(rate), .REMOTE_OFFSET_MSB(), .REMOTE_OFFSET_LSB(),
		.REMOTE_OVERTEMP_LIMIT(rot), .LOCAL_OVERTEMP_LIMIT(), .OVERTEMP_HYSTERESIS(hyst)
	);
	function automatic logic [16:0] next_rand(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	function automatic int needed(input logic [7:0] c);
		return $countones(c[3:1]) + 1;
	endfunction
	function automatic logic [7:0] status_exp(input logic b, hi, input logic [1:0] f);
		return {b, hi, 4'h0, f};
	endfunction
	task automatic check(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic frame(input logic [7:0] a, input int n, input logic [7:0] d0, d1, d2);
		logic [7:0] b [3];
		b = '{d0, d1, d2};
		host_model_inst.start();
		host_model_inst.xfer9({a, 1'b1}, r);
		ack = {3'b000, !r[0]};
		for (int i = 0; i < n; i++)
		begin
			host_model_inst.xfer9({b[i], 1'b1}, r);
			v = r[8:1];
			ack[i + 1] = !r[0];
		end
		host_model_inst.stop();
	endtask
	task automatic rdreg(input logic [7:0] p);
		frame(8'h98, 1, p, 8'h00, 8'h00);
		frame(8'h99, 1, 8'hFF, 8'h00, 8'h00);
	endtask
	task automatic wr(input logic [7:0] p, d);
		frame(8'h98, 2, p, d, 8'h00);
		check("write ack", 8'h07, {4'h0, ack});
	endtask
	task automatic meas(input logic [7:0] t);
		ltemp <= t;
		host_model_inst.q(1);
		done <= 1'b1;
		host_model_inst.q(1);
		done <= 1'b0;
		host_model_inst.q(2);
	endtask
	initial
	begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		check("remote overtemp port", 8'h6C, rot);
		check("hysteresis port", 8'h0A, hyst);
		for (int i = 0; i < 9; i++)
		begin
			rdreg(rst_addr[i]);
			check("reset value", rst_val[i], v);
		end
		for (int i = 0; i < 4; i++)
		begin
			lfsr = next_rand(lfsr);
			busy <= lfsr[8];
			flags <= lfsr[10:9];
			wr(tmon_pkg::WR_CONFIG, lfsr[7:0]);
			check("config port", lfsr[7:0], cfg);
			rdreg(tmon_pkg::RD_CONFIG);
			check("config read", lfsr[7:0], v);
			rdreg(tmon_pkg::RD_STATUS);
			check("status", status_exp(lfsr[8], 1'b0, lfsr[10:9]), v);
		end
		wr(tmon_pkg::WR_CONFIG, 8'h00);
		ltemp <= lfsr[7:0];
		frame(8'h98, 2, tmon_pkg::RD_LOCAL_TEMP, 8'h5A, 8'h00);
		check("read-only data ack", 8'h03, {4'h0, ack});
		frame(8'h99, 1, 8'hFF, 8'h00, 8'h00);
		check("pointer kept", lfsr[7:0], v);
		frame(8'h98, 3, tmon_pkg::WR_RATE, 8'h05, 8'h07);
		check("third byte ack", 8'h07, {4'h0, ack});
		check("rate port", 8'h05, rate);
		rdreg(tmon_pkg::RD_RATE);
		check("rate", 8'h05, v);
		frame(8'h9A, 1, 8'h00, 8'h00, 8'h00);
		check("other address", 8'h00, {4'h0, ack});
		frame(8'h19, 1, 8'hFF, 8'h00, 8'h00);
		check("quiet alert answer", 8'h00, {4'h0, ack});
		wr(tmon_pkg::WR_ONE_SHOT, lfsr[7:0]);
		check("trigger pulses", 8'h01, trig_count[7:0]);
		wr(tmon_pkg::RW_VIOLATION_COUNT, 8'h06);
		for (int i = 0; i < 6; i++)
		begin
			meas(temps[i]);
			run = (temps[i] > 8'h55) ? run + 1 : 0;
			check("alert", {7'h00, run >= needed(8'h06)}, {7'h00, alert_oe});
		end
		frame(8'h19, 1, 8'hFF, 8'h00, 8'h00);
		check("alert answer", 8'h99, v);
		check("alert held", 8'h01, {7'h00, alert_oe});
		meas(8'h20);
		rdreg(tmon_pkg::RD_STATUS);
		check("status latched", status_exp(busy, 1'b1, flags), v);
		rdreg(tmon_pkg::RD_STATUS);
		check("status cleared", status_exp(busy, 1'b0, flags), v);
		frame(8'h19, 1, 8'hFF, 8'h00, 8'h00);
		check("alert released", 8'h00, {7'h00, alert_oe});
		wr(tmon_pkg::RW_VIOLATION_COUNT, 8'h86);
		ltemp <= 8'h55;
		frame(8'h98, 1, tmon_pkg::RD_LOCAL_TEMP, 8'h00, 8'h00);
		host_model_inst.start();
		host_model_inst.xfer9(9'h133, r);
		host_model_inst.q(2);
		check("read bit driven", 8'h01, {7'h00, sda_oe});
		host_model_inst.q(TO + 20);
		check("timeout release", 8'h00, {7'h00, sda_oe});
		host_model_inst.stop();
		rdreg(tmon_pkg::RD_LOCAL_TEMP);
		check("after timeout", 8'h55, v);
		// An open sensor counts as a violation; the count code is now three.
		ropen <= 1'b1;
		repeat (3) meas(8'h20);
		check("open alert", 8'h01, {7'h00, alert_oe});
		ropen <= 1'b0;
		rdreg(tmon_pkg::RD_STATUS);
		check("open flag", status_exp(busy, 1'b0, flags) | 8'h04, v);
		report_and_stop();
	end
	initial
	begin
		repeat (100000) @(posedge clock);
		failures++;
		report_and_stop();
	end
endmodule
